// ---- common/dcmc_pkg.sv ----
// Constants and types for the DMA channel mode control block
package dcmc_pkg;
  localparam int NUM_CH = 8;
  localparam int CH_PER_GRP = 4;
  localparam int ADDR_W = 16;
  localparam int MODE_BITS_W = 6;
  // I/O port of each channel group
  localparam logic [15:0] PORT_GRP0 = 16'h000B;
  localparam logic [15:0] PORT_GRP1 = 16'h00D6;
  // Write data layout
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam int STORE_LSB = 2;
  // Stored field positions within the six kept bits
  localparam int MODE_POS = 4;
  localparam int DIR_POS = 3;
  localparam int AUTO_POS = 2;
  localparam int TYPE_POS = 0;
  // Values after reset or master clear
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [5:0] MODE_RST_CASCADE = 6'h30;
  localparam int CASCADE_CH = 4;
  // Decoded flags after reset: demand and verify everywhere but the cascade channel
  localparam logic [7:0] DEMAND_RST = 8'hEF;
  localparam logic [7:0] VERIFY_RST = 8'hEF;
  localparam logic [7:0] CASCADE_RST = 8'h10;
  typedef enum logic [1:0] {
    DCMC_DEMAND = 2'h0,
    DCMC_SINGLE = 2'h1,
    DCMC_BLOCK = 2'h2,
    DCMC_CASCADE = 2'h3
  } dcmc_mode_t;
  typedef enum logic [1:0] {
    DCMC_VERIFY = 2'h0,
    DCMC_WRITE = 2'h1,
    DCMC_READ = 2'h2,
    DCMC_ILLEGAL = 2'h3
  } dcmc_type_t;
endpackage

// ---- design/dcmc_mode_store.sv ----
// Six-bit mode storage for one DMA channel
`timescale 1ns/1ps
`default_nettype none
module dcmc_mode_store #(
  parameter logic FORCE_CASCADE = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic master_clear,
  input wire logic wr_en,
  input wire logic [dcmc_pkg::MODE_BITS_W-1:0] wr_bits,
  // Stored value
  output logic [dcmc_pkg::MODE_BITS_W-1:0] mode_bits
);
  import dcmc_pkg::*;

  localparam logic [MODE_BITS_W-1:0] RST_VAL = FORCE_CASCADE ? MODE_RST_CASCADE : MODE_RST;

  logic [MODE_BITS_W-1:0] next_mode_bits;

  always_comb begin
    next_mode_bits = mode_bits;
    if (master_clear) begin
      next_mode_bits = RST_VAL;
    end else if (wr_en) begin
      next_mode_bits = wr_bits;
    end
    // Mode field pinned so no write can move it off cascade
    if (FORCE_CASCADE) begin
      next_mode_bits[MODE_POS+:2] = DCMC_CASCADE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_bits <= RST_VAL;
    end else begin
      mode_bits <= next_mode_bits;
    end
  end
endmodule
`default_nettype wire

// ---- design/dcmc_top.sv ----
// DMA channel mode control: mode ports, per-channel storage and decode
//
// Summary of operation
// - Mode field: demand, single, block, cascade.
// - Direction bit clear counts up, set down.
// - Reset or master clear selects increment.
// - Autoinit reloads current registers at terminal count.
// - No autoinit: no reload; reset clears it.
// - Type field: verify, write, read; 11 illegal.
// - Reset or master clear selects verify.
// - Write type moves I/O into memory.
// - Read type moves memory out to I/O.
// - Verify generates addresses and terminal count normally.
// - Verify keeps memory and I/O strobes inactive.
// - Cascade mode ignores the transfer type.
// - Low two bits pick the channel written.
// - Select 00..11 maps first..fourth group channel.
// - Only upper six bits stored; select dropped.
// - Channel four stays in cascade always.
// - Other channels default demand, increment, verify, off.
// - Group ports at 0Bh and 0D6h.
`timescale 1ns/1ps
`default_nettype none
module dcmc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // I/O write port from the host bus, same clock
  input wire logic [dcmc_pkg::ADDR_W-1:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic master_clear,
  // Terminal count from the address and count logic
  input wire logic [dcmc_pkg::NUM_CH-1:0] tc_in,
  // Decoded transfer mode per channel
  output logic [dcmc_pkg::NUM_CH-1:0] mode_demand,
  output logic [dcmc_pkg::NUM_CH-1:0] mode_single,
  output logic [dcmc_pkg::NUM_CH-1:0] mode_block,
  output logic [dcmc_pkg::NUM_CH-1:0] mode_cascade,
  // Address direction and autoinitialize
  output logic [dcmc_pkg::NUM_CH-1:0] addr_decrement,
  output logic [dcmc_pkg::NUM_CH-1:0] autoinit_en,
  output logic [dcmc_pkg::NUM_CH-1:0] autoinit_reload,
  // Transfer type and bus strobe control
  output logic [dcmc_pkg::NUM_CH-1:0] xfer_verify,
  output logic [dcmc_pkg::NUM_CH-1:0] xfer_io_to_mem,
  output logic [dcmc_pkg::NUM_CH-1:0] xfer_mem_to_io,
  output logic [dcmc_pkg::NUM_CH-1:0] cmd_strobe_en,
  output logic [dcmc_pkg::NUM_CH-1:0] tc_out
);
  import dcmc_pkg::*;

  logic grp0_hit;
  logic grp1_hit;
  logic [SEL_W-1:0] sel;
  logic [NUM_CH-1:0] wr_sel;
  logic [MODE_BITS_W-1:0] wr_bits;
  // Per-channel store: [5:4] mode, [3] decrement, [2] autoinit, [1:0] type.
  // Write-only; software must keep its own copy to know the settings.
  logic [MODE_BITS_W-1:0] mode_bits [NUM_CH];

  logic [NUM_CH-1:0] next_mode_demand;
  logic [NUM_CH-1:0] next_mode_single;
  logic [NUM_CH-1:0] next_mode_block;
  logic [NUM_CH-1:0] next_mode_cascade;
  logic [NUM_CH-1:0] next_addr_decrement;
  logic [NUM_CH-1:0] next_autoinit_en;
  logic [NUM_CH-1:0] next_autoinit_reload;
  logic [NUM_CH-1:0] next_xfer_verify;
  logic [NUM_CH-1:0] next_xfer_io_to_mem;
  logic [NUM_CH-1:0] next_xfer_mem_to_io;
  logic [NUM_CH-1:0] next_cmd_strobe_en;
  logic [NUM_CH-1:0] next_tc_out;

  // Write is taken at the edge with io_wr high and lands in the store
  // there; the flags below follow one edge later. Exact 16-bit match,
  // so no other port aliases onto the mode ports.
  always_comb begin
    grp0_hit = 1'b0;
    grp1_hit = 1'b0;
    if (io_wr && io_addr == PORT_GRP0) begin
      grp0_hit = 1'b1;
    end else if (io_wr && io_addr == PORT_GRP1) begin
      grp1_hit = 1'b1;
    end
  end

  // Channel select within the group; a master clear in the store wins
  always_comb begin
    sel = io_wdata[SEL_LSB+:SEL_W];
    wr_bits = io_wdata[7:STORE_LSB];
    wr_sel = '0;
    for (int g = 0; g < CH_PER_GRP; g++) begin
      wr_sel[g] = grp0_hit && (sel == g[SEL_W-1:0]);
      wr_sel[g+CH_PER_GRP] = grp1_hit && (sel == g[SEL_W-1:0]);
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dcmc_mode_store #(
      .FORCE_CASCADE(c == CASCADE_CH)
    ) u_store (
      .clk_sys(clk_sys),
      .rst(rst),
      .master_clear(master_clear),
      .wr_en(wr_sel[c]),
      .wr_bits(wr_bits),
      .mode_bits(mode_bits[c])
    );
  end

  // Transfer mode flags, exactly one set per channel
  always_comb begin
    logic [1:0] m;
    m = 2'h0;
    next_mode_demand = '0;
    next_mode_single = '0;
    next_mode_block = '0;
    next_mode_cascade = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      m = mode_bits[c][MODE_POS+:2];
      next_mode_demand[c] = (m == DCMC_DEMAND);
      next_mode_single[c] = (m == DCMC_SINGLE);
      next_mode_block[c] = (m == DCMC_BLOCK);
      next_mode_cascade[c] = (m == DCMC_CASCADE);
    end
  end

  // Reset values match the decode of the stored reset values
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_demand <= DEMAND_RST;
      mode_single <= 8'h00;
      mode_block <= 8'h00;
      mode_cascade <= CASCADE_RST;
    end else begin
      mode_demand <= next_mode_demand;
      mode_single <= next_mode_single;
      mode_block <= next_mode_block;
      mode_cascade <= next_mode_cascade;
    end
  end

  // Stored direction and autoinitialize settings
  always_comb begin
    next_addr_decrement = '0;
    next_autoinit_en = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      next_addr_decrement[c] = mode_bits[c][DIR_POS];
      next_autoinit_en[c] = mode_bits[c][AUTO_POS];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_decrement <= 8'h00;
      autoinit_en <= 8'h00;
    end else begin
      addr_decrement <= next_addr_decrement;
      autoinit_en <= next_autoinit_en;
    end
  end

  // Terminal count path; tc_in comes from count logic on this clock
  always_comb begin
    next_autoinit_reload = '0;
    next_tc_out = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      // Reload only with autoinit set; otherwise current registers hold
      next_autoinit_reload[c] = tc_in[c] && mode_bits[c][AUTO_POS];
      // Terminal count passes through for every type, verify included
      next_tc_out[c] = tc_in[c];
    end
  end

  // Same delay on both keeps reload aligned with the terminal count copy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      autoinit_reload <= 8'h00;
      tc_out <= 8'h00;
    end else begin
      autoinit_reload <= next_autoinit_reload;
      tc_out <= next_tc_out;
    end
  end

  // Transfer type and strobe enables; an illegal type moves no data
  always_comb begin
    logic [1:0] t;
    logic casc;
    t = 2'h0;
    casc = 1'b0;
    next_xfer_verify = '0;
    next_xfer_io_to_mem = '0;
    next_xfer_mem_to_io = '0;
    next_cmd_strobe_en = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      t = mode_bits[c][TYPE_POS+:2];
      casc = (mode_bits[c][MODE_POS+:2] == DCMC_CASCADE);
      next_xfer_verify[c] = !casc && (t == DCMC_VERIFY);
      next_xfer_io_to_mem[c] = !casc && (t == DCMC_WRITE);
      next_xfer_mem_to_io[c] = !casc && (t == DCMC_READ);
      // Verify still runs addresses but must leave the bus commands idle
      next_cmd_strobe_en[c] = !casc && (t == DCMC_WRITE || t == DCMC_READ);
    end
  end

  // The cascade channel has no transfer type, so its verify flag is clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xfer_verify <= VERIFY_RST;
      xfer_io_to_mem <= 8'h00;
      xfer_mem_to_io <= 8'h00;
      cmd_strobe_en <= 8'h00;
    end else begin
      xfer_verify <= next_xfer_verify;
      xfer_io_to_mem <= next_xfer_io_to_mem;
      xfer_mem_to_io <= next_xfer_mem_to_io;
      cmd_strobe_en <= next_cmd_strobe_en;
    end
  end
endmodule
`default_nettype wire

// ---- test/dcmc_host.sv ----
// Host model writing the mode ports
`timescale 1ns/1ps
`default_nettype none
module dcmc_host (
  // Clock
  input wire logic clk_sys,
  // I/O write port
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr
);
  initial begin
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    io_wr = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
  endtask
  // Released lines invert so stale data never looks valid
  task automatic idle();
    io_wr = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask
endmodule
`default_nettype wire

// ---- test/dcmc_sva.sv ----
// Mode control port assertions
`timescale 1ns/1ps
`default_nettype none
module dcmc_sva (
  // Clock, reset and inputs
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic master_clear,
  input wire logic [7:0] tc_in,
  // Outputs
  input wire logic [7:0] mode_demand,
  input wire logic [7:0] mode_single,
  input wire logic [7:0] mode_block,
  input wire logic [7:0] mode_cascade,
  input wire logic [7:0] addr_decrement,
  input wire logic [7:0] autoinit_en,
  input wire logic [7:0] autoinit_reload,
  input wire logic [7:0] xfer_verify,
  input wire logic [7:0] xfer_io_to_mem,
  input wire logic [7:0] xfer_mem_to_io,
  input wire logic [7:0] cmd_strobe_en,
  input wire logic [7:0] tc_out
);
  import dcmc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ch4_cascade: assert property (
    mode_cascade[4]) else $error("ch4 left cascade");
  for (genvar i = 0; i < 8; i++) begin : g_ch
    wire logic hit = io_wr && io_wdata[1:0] == 2'(i % 4)
      && io_addr == (i < 4 ? PORT_GRP0 : PORT_GRP1);
    sequence s_wr;
      hit && !master_clear;
    endsequence
    sequence s_idle;
      !hit && !master_clear;
    endsequence
    a_mode_onehot: assert property (
      $onehot({mode_demand[i], mode_single[i], mode_block[i], mode_cascade[i]}))
      else $error("mode not one-hot");
    a_verify_quiet: assert property (
      xfer_verify[i] |-> !cmd_strobe_en[i]) else $error("strobe in verify");
    a_cascade_quiet: assert property (
      mode_cascade[i] |-> !(xfer_verify[i] | cmd_strobe_en[i])) else $error("cascade type");
    a_tc_follow: assert property (
      tc_out[i] == $past(tc_in[i])) else $error("tc delay");
    a_reload_gate: assert property (
      autoinit_reload[i] == (tc_out[i] && autoinit_en[i])) else $error("reload");
    a_write_dir: assert property (
      s_wr |-> ##2 addr_decrement[i] == $past(io_wdata[5], 2)
      && autoinit_en[i] == $past(io_wdata[4], 2)) else $error("write lost");
    a_clear_dflt: assert property (
      master_clear |-> ##2 !addr_decrement[i] && !autoinit_en[i]
      && mode_cascade[i] == (i == 4) && mode_demand[i] == (i != 4)
      && xfer_verify[i] == (i != 4)) else $error("clear");
    a_other_kept: assert property (
      s_idle |-> ##2 $stable({mode_block[i], addr_decrement[i], xfer_verify[i]}))
      else $error("setting changed");
  end
endmodule
bind dcmc_top dcmc_sva dcmc_sva_inst (.*);
`default_nettype wire

// ---- test/dcmc_top_tb.sv ----
// Bench for the DMA channel mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module dcmc_top_tb;
  logic clk_sys, rst, io_wr, master_clear;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, tc_in, mode_demand, mode_single, mode_block, mode_cascade;
  logic [7:0] addr_decrement, autoinit_en, autoinit_reload, xfer_verify, xfer_io_to_mem;
  logic [7:0] xfer_mem_to_io, cmd_strobe_en, tc_out;
  logic [5:0] m [8];
  int err_total = 0;
  int total_checks = 0;
  // Port, byte, channel hit (8 = none)
  logic [27:0] rows [10] = '{28'h000B551, 28'h000BA80, 28'h000BEE2, 28'h000B1F3,
    28'h00D6644, 28'h00D6395, 28'h00D6C66, 28'h00D68B7, 28'h000CFF8, 28'h000B411};
  dcmc_top dcmc_top_inst (.*);
  dcmc_host dcmc_host_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [79:0] expv();
    logic [79:0] v;
    logic [1:0] ty;
    for (int i = 0; i < 8; i++) begin
      // Cascade hides the type
      ty = m[i][5:4] == 2'h3 ? 2'h3 : m[i][1:0];
      for (int j = 0; j < 4; j++) begin
        v[8*j+i] = m[i][5:4] == 2'(j);
        v[48+8*j+i] = ty == 2'(j);
      end
      v[32+i] = m[i][3];
      v[40+i] = m[i][2];
      v[72+i] = v[56+i] | v[64+i];
    end
    return v;
  endfunction
  task automatic check_all(input string s);
    `CHK("settings", expv(), {cmd_strobe_en, xfer_mem_to_io, xfer_io_to_mem, xfer_verify,
      autoinit_en, addr_decrement, mode_cascade, mode_block, mode_single, mode_demand})
    $display("test %s done", s);
  endtask
  task automatic clear_model();
    foreach (m[i]) m[i] = i == 4 ? 6'h30 : 6'h00;
  endtask
  task automatic put(input logic [27:0] r);
    dcmc_host_inst.wr(r[27:12], r[11:4]);
    dcmc_host_inst.idle();
    if (r[3:0] < 4'h8) m[r[3:0]] = r[3:0] == 4'h4 ? {2'h3, r[9:6]} : r[11:6];
    @(negedge clk_sys);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    master_clear = 1'b0;
    tc_in = 8'h00;
    clear_model();
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check_all("reset");
    foreach (rows[k]) begin
      put(rows[k]);
      check_all("row");
    end
    // Both writes modelled, so a lost first write shows up
    dcmc_host_inst.wr(16'h00D6, 8'h46);
    m[6] = 6'h11;
    put(28'h00D6B15);
    check_all("back to back");
    master_clear = 1'b1;
    dcmc_host_inst.wr(16'h000B, 8'hFF);
    master_clear = 1'b0;
    dcmc_host_inst.idle();
    clear_model();
    @(negedge clk_sys);
    check_all("clear");
    put(28'h000B122);
    tc_in = 8'h0C;
    @(negedge clk_sys);
    tc_in = 8'h00;
    `CHK("tc", 16'h0C04, {tc_out, autoinit_reload})
    @(negedge clk_sys);
    `CHK("tc end", 16'h0000, {tc_out, autoinit_reload})
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    clear_model();
    check_all("second reset");
    repeat (2) @(negedge clk_sys);
    check_all("after reset");
    test_done();
  end
  initial begin
    // Tests need under 100 cycles
    repeat (2000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
